// File: inc/cta_defines.svh
`ifndef CTA_DEFINES_SVH
`define CTA_DEFINES_SVH

// Clock and timing, each time in its own unit
`define CTA_CLK_HZ 200000000
`define CTA_TICK_MS 1000
`define CTA_TICK_CYC (`CTA_CLK_HZ / 1000 * `CTA_TICK_MS)
`define CTA_WARMUP_H 2
`define CTA_WARMUP_S (`CTA_WARMUP_H * 3600 * 1000 / `CTA_TICK_MS)
`define CTA_BLINK_MS 500
`define CTA_BLINK_CYC (`CTA_CLK_HZ / 1000 * `CTA_BLINK_MS)
`define CTA_DEBOUNCE_MS 20
`define CTA_DEBOUNCE_CYC (`CTA_CLK_HZ / 1000 * `CTA_DEBOUNCE_MS)

// Register byte offsets
`define CTA_OFF_CTRL 8'h00
`define CTA_OFF_STATUS 8'h04
`define CTA_OFF_GAIN 8'h08
`define CTA_OFF_IRQ_STAT 8'h0c
`define CTA_OFF_IRQ_MASK 8'h10
`define CTA_OFF_BASELINE 8'h14
`define CTA_OFF_SAMPLE 8'h18

// Control register fields
`define CTA_CTRL_MID 0
`define CTA_CTRL_CAPTURE 1

// Status register fields
`define CTA_ST_WARMUP 0
`define CTA_ST_ALARM 1
`define CTA_ST_FAULT 2
`define CTA_ST_BASE_VALID 3
`define CTA_ST_CONC_LSB 16

// Interrupt status bits
`define CTA_IRQ_W 5
`define CTA_IRQ_WARM_DONE 0
`define CTA_IRQ_ALARM_ON 1
`define CTA_IRQ_ALARM_OFF 2
`define CTA_IRQ_FAULT_ON 3
`define CTA_IRQ_BASELINE 4

// Gain reset value and fraction bits
`define CTA_GAIN_RST 16'h0100
`define CTA_GAIN_FRAC 8

// Concentrations in ppm
`define CTA_PPM_BASE 16'h0190
`define CTA_PPM_MAX_LOW 16'h0fa0
`define CTA_PPM_MAX_MID 16'h1f40
`define CTA_LOW_ON '{16'h0320, 16'h03e8, 16'h05dc, 16'h07d0}
`define CTA_LOW_OFF '{16'h02d0, 16'h0384, 16'h0546, 16'h0708}
`define CTA_MID_ON '{16'h03e8, 16'h07d0, 16'h1388, 16'h1f40}
`define CTA_MID_OFF '{16'h0384, 16'h0708, 16'h1194, 16'h1c20}

// Concentration output in millivolts
`define CTA_MV_WARMUP 12'h190
`define CTA_MV_FULL 12'hfa0

`endif

// File: inc/cta_pkg.sv
package cta_pkg;
	typedef logic [15:0] cta_word_t;
	typedef logic [11:0] cta_mv_t;
	typedef enum logic [0:0] {
		CTA_ST_WARM = 1'b0,
		CTA_ST_RUN = 1'b1
	} cta_state_e;
endpackage

// File: hdl/cta_debounce.sv
`timescale 1ns/100ps
`default_nettype none
`include "cta_defines.svh"
module cta_debounce #(
	parameter int unsigned STABLE_CYC = `CTA_DEBOUNCE_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic raw,
	output logic press
);
	logic [31:0] cnt_q;
	logic level_q;
	logic differs;
	logic settled;

	assign differs = raw != level_q;
	assign settled = differs && (cnt_q == 32'(STABLE_CYC - 1));

	// Level follows the input only after it has stayed put long enough
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 32'h0000_0000;
			level_q <= 1'b0;
			press <= 1'b0;
		end else begin
			cnt_q <= (differs && !settled) ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
			if (settled) begin
				level_q <= raw;
			end
			press <= settled && raw;
		end
	end
endmodule
`default_nettype wire

// File: hdl/cta_top.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cta_defines.svh"
module cta_top #(
	parameter int unsigned TICK_CYC = `CTA_TICK_CYC,
	parameter int unsigned WARMUP_S = `CTA_WARMUP_S,
	parameter int unsigned BLINK_CYC = `CTA_BLINK_CYC,
	parameter int unsigned DEBOUNCE_CYC = `CTA_DEBOUNCE_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire cta_pkg::cta_word_t sensor_sample,
	input wire logic heater_broken,
	input wire logic jumper_broken,
	input wire logic threshold_select_high_jumper,
	input wire logic threshold_select_low_jumper,
	input wire logic baseline_switch,
	output logic alarm_out,
	output logic fault_out_o,
	output logic fault_out_oe,
	output cta_pkg::cta_mv_t conc_mv,
	output logic led_green,
	output logic led_yellow,
	output logic led_red
);
	import cta_pkg::*;

	localparam cta_word_t LOW_ON [4] = `CTA_LOW_ON;
	localparam cta_word_t LOW_OFF [4] = `CTA_LOW_OFF;
	localparam cta_word_t MID_ON [4] = `CTA_MID_ON;
	localparam cta_word_t MID_OFF [4] = `CTA_MID_OFF;

	cta_state_e state_q, state_d;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [31:0] warm_cnt_q;
	logic [31:0] blink_cnt_q;
	logic blink_q;
	logic mid_q;
	cta_word_t gain_q;
	cta_word_t baseline_q;
	logic base_valid_q;
	cta_word_t sample_q;
	cta_word_t conc_q;
	logic [`CTA_IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_set;
	logic alarm_q;
	logic fault_q;

	// Bus decode
	logic access, rd_phase, wr_en;
	logic hit_ctrl, hit_status, hit_gain, hit_istat, hit_imask, hit_base, hit_sample, hit_any;
	logic [31:0] rd_mux;
	assign access = psel && penable;
	assign rd_phase = access && !pready;
	assign wr_en = access && pready && pwrite;
	assign hit_ctrl = paddr == `CTA_OFF_CTRL;
	assign hit_status = paddr == `CTA_OFF_STATUS;
	assign hit_gain = paddr == `CTA_OFF_GAIN;
	assign hit_istat = paddr == `CTA_OFF_IRQ_STAT;
	assign hit_imask = paddr == `CTA_OFF_IRQ_MASK;
	assign hit_base = paddr == `CTA_OFF_BASELINE;
	assign hit_sample = paddr == `CTA_OFF_SAMPLE;
	assign hit_any = hit_ctrl | hit_status | hit_gain | hit_istat | hit_imask | hit_base | hit_sample;

	logic [31:0] status_word;
	assign status_word = {conc_q, 12'h000, base_valid_q, fault_q, alarm_q, state_q == CTA_ST_WARM};
	assign rd_mux = hit_ctrl ? {31'h0000_0000, mid_q} :
		hit_status ? status_word :
		hit_gain ? {16'h0000, gain_q} :
		hit_istat ? {27'h0000_000, irq_stat_q} :
		hit_imask ? {27'h0000_000, irq_mask_q} :
		hit_base ? {16'h0000, baseline_q} :
		hit_sample ? {16'h0000, sample_q} : 32'h0000_0000;

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= rd_phase;
			pslverr <= rd_phase && !hit_any;
			if (rd_phase) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	logic sw_capture;
	assign sw_capture = wr_en && hit_ctrl && pwdata[`CTA_CTRL_CAPTURE];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mid_q <= 1'b0;
			gain_q <= `CTA_GAIN_RST;
			irq_mask_q <= '0;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				mid_q <= pwdata[`CTA_CTRL_MID];
			end
			if (hit_gain) begin
				gain_q <= pwdata[15:0];
			end
			if (hit_imask) begin
				irq_mask_q <= pwdata[`CTA_IRQ_W-1:0];
			end
		end
	end

	// One second tick and half second blink phase
	logic tick_wrap, blink_wrap;
	assign tick_wrap = tick_cnt_q == 32'(TICK_CYC - 1);
	assign blink_wrap = blink_cnt_q == 32'(BLINK_CYC - 1);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
			blink_cnt_q <= 32'h0000_0000;
			blink_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
			tick_q <= tick_wrap;
			blink_cnt_q <= blink_wrap ? 32'h0000_0000 : blink_cnt_q + 32'h0000_0001;
			if (blink_wrap) begin
				blink_q <= !blink_q;
			end
		end
	end

	// Baseline switch
	logic press;
	cta_debounce #(
		.STABLE_CYC(DEBOUNCE_CYC)
	) u_debounce (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.raw(baseline_switch),
		.press(press)
	);

	logic capture, warm_done, warm_expire;
	assign capture = press || sw_capture;
	assign warm_expire = (state_q == CTA_ST_WARM) && tick_q && (warm_cnt_q == 32'(WARMUP_S - 1));
	assign warm_done = (state_q == CTA_ST_WARM) && (capture || warm_expire);

	always_comb begin
		state_d = state_q;
		case (state_q)
			CTA_ST_WARM: begin
				if (warm_done) begin
					state_d = CTA_ST_RUN;
				end
			end
			CTA_ST_RUN: begin
				state_d = CTA_ST_RUN;
			end
			default: begin
				state_d = CTA_ST_WARM;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= CTA_ST_WARM;
			warm_cnt_q <= 32'h0000_0000;
			baseline_q <= 16'h0000;
			base_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if ((state_q == CTA_ST_WARM) && tick_q) begin
				warm_cnt_q <= warm_cnt_q + 32'h0000_0001;
			end
			// Expiry without a press takes the reading at that moment as baseline
			if (capture || (warm_expire && !base_valid_q)) begin
				baseline_q <= sensor_sample;
				base_valid_q <= 1'b1;
			end
		end
	end

	// Concentration from change against baseline
	logic signed [16:0] diff;
	logic signed [33:0] scaled;
	logic signed [33:0] ppm_raw;
	cta_word_t ppm_max, ppm_new;
	assign diff = $signed({1'b0, baseline_q}) - $signed({1'b0, sensor_sample});
	assign scaled = (34'(diff) * $signed({18'h0_0000, gain_q})) >>> `CTA_GAIN_FRAC;
	assign ppm_raw = scaled + $signed({18'h0_0000, `CTA_PPM_BASE});
	assign ppm_max = mid_q ? `CTA_PPM_MAX_MID : `CTA_PPM_MAX_LOW;
	assign ppm_new = (ppm_raw < 34'sh0_0000_0000) ? 16'h0000 :
		(ppm_raw > $signed({18'h0_0000, ppm_max})) ? ppm_max : ppm_raw[15:0];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_q <= 16'h0000;
			conc_q <= `CTA_PPM_BASE;
		end else if (capture) begin
			sample_q <= sensor_sample;
			conc_q <= `CTA_PPM_BASE;
		end else if (tick_q && (state_q == CTA_ST_RUN)) begin
			sample_q <= sensor_sample;
			conc_q <= ppm_new;
		end
	end

	// Threshold select with hysteresis
	logic [1:0] mode;
	cta_word_t thr_on, thr_off;
	logic fault_now, alarm_d;
	assign mode = {threshold_select_high_jumper, threshold_select_low_jumper};
	assign thr_on = mid_q ? MID_ON[mode] : LOW_ON[mode];
	assign thr_off = mid_q ? MID_OFF[mode] : LOW_OFF[mode];
	assign fault_now = heater_broken || jumper_broken;
	assign alarm_d = (state_q != CTA_ST_RUN) || fault_now ? 1'b0 :
		alarm_q ? (conc_q > thr_off) : (conc_q >= thr_on);

	// Analog output code in millivolts
	cta_mv_t mv_meas, mv_d;
	assign mv_meas = mid_q ? conc_q[12:1] : (conc_q > 16'(`CTA_MV_FULL) ? `CTA_MV_FULL : conc_q[11:0]);
	assign mv_d = fault_now ? `CTA_MV_FULL :
		(state_q == CTA_ST_WARM) ? `CTA_MV_WARMUP : mv_meas;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			alarm_q <= 1'b0;
			fault_q <= 1'b0;
			alarm_out <= 1'b0;
			fault_out_o <= 1'b0;
			fault_out_oe <= 1'b0;
			conc_mv <= `CTA_MV_WARMUP;
			led_green <= 1'b0;
			led_yellow <= 1'b0;
			led_red <= 1'b0;
		end else begin
			alarm_q <= alarm_d;
			fault_q <= fault_now;
			alarm_out <= alarm_d;
			fault_out_o <= 1'b0;
			fault_out_oe <= fault_now;
			conc_mv <= mv_d;
			led_green <= (state_d == CTA_ST_WARM) ? blink_q : 1'b1;
			led_yellow <= fault_now && blink_q;
			led_red <= alarm_d;
		end
	end

	// Sticky event bits, a new event wins over a clear in the same cycle
	assign irq_set[`CTA_IRQ_WARM_DONE] = warm_done;
	assign irq_set[`CTA_IRQ_ALARM_ON] = alarm_d && !alarm_q;
	assign irq_set[`CTA_IRQ_ALARM_OFF] = !alarm_d && alarm_q;
	assign irq_set[`CTA_IRQ_FAULT_ON] = fault_now && !fault_q;
	assign irq_set[`CTA_IRQ_BASELINE] = capture;
	assign irq_stat_d = (irq_stat_q & ~((wr_en && hit_istat) ? pwdata[`CTA_IRQ_W-1:0] : '0)) | irq_set;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq <= |(irq_stat_d & irq_mask_q);
		end
	end
endmodule
`default_nettype wire

// File: verif/cta_props.sv
`timescale 1ns/100ps
`default_nettype none
module cta_props #(
	parameter int unsigned BLINK_CYC = 5
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic heater_broken,
	input wire logic jumper_broken,
	input wire logic alarm_out,
	input wire logic fault_out_o,
	input wire logic fault_out_oe,
	input wire cta_pkg::cta_mv_t conc_mv,
	input wire logic led_green,
	input wire logic led_yellow,
	input wire logic led_red
);
	import cta_pkg::*;
	logic [31:0] dark_q, dark_d;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Length of the current dark spell of the green indicator
	assign dark_d = led_green ? 32'h0000_0000 : dark_q + 32'h0000_0001;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dark_q <= 32'h0000_0000;
		end else begin
			dark_q <= dark_d;
		end
	end
	a_blink_period: assert property (dark_q <= BLINK_CYC + 1)
		else $error("green dark too long");
	a_fault_drive_low: assert property (fault_out_o == 1'b0)
		else $error("fault line driven high");
	a_fault_on: assert property ((heater_broken || jumper_broken) |=> fault_out_oe)
		else $error("fault not raised");
	a_fault_off: assert property (!(heater_broken || jumper_broken) |=> !fault_out_oe)
		else $error("fault line not floated");
	a_yellow_quiet: assert property (!fault_out_oe && !$past(fault_out_oe) |-> !led_yellow)
		else $error("yellow lit without fault");
	a_red_alarm: assert property (led_red == alarm_out)
		else $error("red differs from alarm");
	a_alarm_run: assert property (alarm_out |-> led_green)
		else $error("alarm during warm-up");
	a_warm_level: assert property (!led_green && !fault_out_oe && !$past(fault_out_oe) |-> conc_mv == 12'h190)
		else $error("warm-up level wrong");
	a_fault_level: assert property (fault_out_oe && $past(fault_out_oe) |-> conc_mv == 12'hfa0)
		else $error("fault level wrong");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
endmodule
`default_nettype wire

// File: verif/cta_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cta_host_model (
	input wire logic fault_out_o,
	input wire logic fault_out_oe,
	output logic fault_line
);
	// Pull-up holds the line high while the device floats it
	assign fault_line = fault_out_oe ? fault_out_o : 1'b1;
endmodule
`default_nettype wire

// File: verif/cta_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cta_top_tb;
	import cta_pkg::*;
	localparam int TICK = 20;
	localparam int WARM_S = 20;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, d;
	cta_word_t sensor_sample = 16'h4000;
	logic heater_broken = 0, jumper_broken = 0, baseline_switch = 0;
	logic threshold_select_high_jumper = 0, threshold_select_low_jumper = 0;
	logic alarm_out, fault_out_o, fault_out_oe, led_green, led_yellow, led_red, fault_line;
	cta_mv_t conc_mv;
	int miscompares = 0, compares = 0, mid = 0, n = 0, on;
	int on_t [2][4] = '{'{800, 1000, 1500, 2000}, '{1000, 2000, 5000, 8000}};
	cta_top #(.TICK_CYC(TICK), .WARMUP_S(WARM_S), .BLINK_CYC(5), .DEBOUNCE_CYC(4)) dut_u (.*);
	cta_host_model host_u (.fault_out_o(fault_out_o), .fault_out_oe(fault_out_oe), .fault_line(fault_line));
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
		xfer(0, a, 32'h0000_0000);
		chk(s, d, x);
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic blink(input logic y);
		logic p;
		n = 0;
		p = y ? led_yellow : led_green;
		repeat (24) begin
			@(negedge ref_clk);
			if ((y ? led_yellow : led_green) !== p) n++;
			p = y ? led_yellow : led_green;
		end
	endtask
	task automatic step(input int p, input logic a);
		@(posedge ref_clk);
		sensor_sample <= 16'h4000 + 16'h0190 - p[15:0];
		settle(45);
		chk("alarm", alarm_out, a);
		chk("red", led_red, a);
		chk("conc_mv", conc_mv, mid ? p / 2 : p);
		xfer(0, 8'h04, 32'h0000_0000);
		chk("status", d, {p[15:0], 12'h000, 2'b10, a, 1'b0});
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		reset_n <= 1;
		settle(0);
		chk("warm level", conc_mv, 12'h190);
		rd(8'h08, 32'h0000_0100, "gain");
		rd(8'h10, 32'h0000_0000, "mask");
		rd(8'h1c, 32'h0000_0000, "unmapped");
		chk("slverr", e, 1);
		xfer(0, 8'h04, 32'h0000_0000);
		chk("warm", d[3:0], 4'h1);
		blink(0);
		chk("green blink", n >= 4, 1);
		xfer(1, 8'h10, 32'h0000_001f);
		@(posedge ref_clk);
		baseline_switch <= 1;
		repeat (2) @(posedge ref_clk);
		baseline_switch <= 0;
		settle(8);
		rd(8'h0c, 32'h0000_0000, "bounce");
		@(posedge ref_clk);
		baseline_switch <= 1;
		repeat (12) @(posedge ref_clk);
		baseline_switch <= 0;
		settle(4);
		xfer(0, 8'h04, 32'h0000_0000);
		chk("run", d[3:0], 4'h8);
		rd(8'h14, 32'h0000_4000, "baseline");
		rd(8'h0c, 32'h0000_0011, "irq stat");
		chk("irq", irq, 1);
		xfer(1, 8'h0c, 32'h0000_001f);
		settle(1);
		chk("irq clear", irq, 0);
		blink(0);
		chk("green steady", {n[7:0], led_green}, 1);
		$display("test baseline done");
		for (int v = 0; v < 2; v++) begin
			// Bring the reading down first so a new variant does not start with the alarm latched
			step(400, 0);
			mid = v;
			xfer(1, 8'h00, v);
			for (int m = 0; m < 4; m++) begin
				@(posedge ref_clk);
				{threshold_select_high_jumper, threshold_select_low_jumper} <= m[1:0];
				on = on_t[v][m];
				step(on - 1, 0);
				step(on, 1);
				step(on * 9 / 10 + 1, 1);
				step(on * 9 / 10, 0);
			end
		end
		$display("test thresholds done");
		step(8000, 1);
		for (int f = 0; f < 2; f++) begin
			xfer(1, 8'h0c, 32'h0000_001f);
			xfer(1, 8'h10, 32'h0000_0000);
			@(posedge ref_clk);
			heater_broken <= (f == 0);
			jumper_broken <= (f == 1);
			settle(3);
			chk("fault line", fault_line, 0);
			chk("alarm in fault", alarm_out, 0);
			chk("fault level", conc_mv, 12'hfa0);
			blink(1);
			chk("yellow blink", n >= 4, 1);
			xfer(0, 8'h0c, 32'h0000_0000);
			chk("fault event", d[3], 1);
			chk("masked", irq, 0);
			@(posedge ref_clk);
			heater_broken <= 0;
			jumper_broken <= 0;
			settle(3);
			chk("fault float", fault_line, 1);
			xfer(1, 8'h10, 32'h0000_0008);
			settle(1);
			chk("unmasked", irq, 1);
		end
		// Software capture in the mid variant takes the present reading as the new baseline
		xfer(1, 8'h00, 32'h0000_0003);
		rd(8'h14, 32'h0000_2250, "sw baseline");
		rd(8'h18, 32'h0000_2250, "sample");
		xfer(0, 8'h04, 32'h0000_0000);
		chk("capture conc", d[31:16], 16'h0190);
		$display("test fault done");
		@(posedge ref_clk);
		reset_n <= 0;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1;
		settle(WARM_S * TICK - 40);
		xfer(0, 8'h04, 32'h0000_0000);
		chk("still warm", d[0], 1);
		settle(80);
		xfer(0, 8'h04, 32'h0000_0000);
		chk("warm over", d[0], 0);
		xfer(0, 8'h0c, 32'h0000_0000);
		chk("warm event", d[0], 1);
		chk("green lit", led_green, 1);
		$display("test warm-up done");
		complete_run();
	end
endmodule
bind cta_top cta_props #(.BLINK_CYC(BLINK_CYC)) props_u (.*);
`default_nettype wire
